// [shared/mmd_pkg.sv]
/*
 * Constants for the min/max, mains-frequency and display sequencing block.
 * Assumes a 200 MHz system clock and 16-bit parameter words.
 */
// Operation
// R01 - averaging filter reaches at least 95% of a step after averaging time
// R02 - every quantity is recomputed once per 10/12 mains-period block
// R03 - new result replaces minimum when lower, maximum when higher
// R04 - extremes copied to nonvolatile store every five minutes, no timestamp
// R05 - writing 001 to parameter 506 clears all extremes at once
// R06 - automatic frequency detection only while phase-one voltage exceeds 10 V
// R07 - sampling rate of current and voltage follows the mains frequency
// R08 - missing voltage in automatic mode raises acknowledgeable error 500
// R09 - without frequency, keep computing with the last measured frequency
// R10 - error clears itself about five seconds after frequency returns
// R11 - missing-frequency error suppressed when a fixed frequency is set
// R12 - frequency parameter accepts 0 (automatic) or 45 to 65 Hz
// R13 - writing 001 to parameter 507 clears all three energy counters together
// R14 - harmonics captured up to the fortieth order
// R15 - THD is root of summed squared orders two upward over fundamental
// R16 - displayed values refresh once per second
// R17 - rotation active only if some screen has rotation time above zero
// R18 - buttons step screen profile; sixty idle seconds resume rotation
// R19 - rotation time 0 to 60 s, common to all profiles, zero stops
// R20 - rotation profile 0 to 3, three presets and one customer profile
// R21 - screen profile 0 to 3, three presets and one customer profile
// R22 - after power-up show first screen of selected screen profile
// R23 - rotation advances to next enabled screen each period, wrapping
`default_nettype none
package mmd_pkg;
    localparam logic [9:0]  ADDR_FREQ     = 10'h022;
    localparam logic [9:0]  ADDR_SCR_PROF = 10'h025;
    localparam logic [9:0]  ADDR_ROT_PROF = 10'h026;
    localparam logic [9:0]  ADDR_ROT_TIME = 10'h027;
    localparam logic [9:0]  ADDR_EXT_CLR  = 10'h1FA;
    localparam logic [9:0]  ADDR_NRG_CLR  = 10'h1FB;
    localparam logic [15:0] CMD_CLEAR     = 16'h0001;
    localparam logic [15:0] FREQ_AUTO     = 16'h0000;
    localparam logic [15:0] FREQ_MIN      = 16'h002D;
    localparam logic [15:0] FREQ_MAX      = 16'h0041;
    localparam logic [15:0] FREQ_RST      = 16'h0000;
    localparam logic [15:0] PROF_MAX      = 16'h0003;
    localparam logic [15:0] ROT_TIME_MAX  = 16'h003C;
    localparam logic [15:0] ROT_TIME_RST  = 16'h0000;
    localparam logic [15:0] ERR_CODE      = 16'h01F4;
    // phase-one voltage in 10 mV units, 10 V threshold
    localparam logic [15:0] PH1_THRESH    = 16'h03E8;
    localparam logic [5:0]  HARM_LAST     = 6'h28;
    localparam logic [5:0]  HARM_FIRST    = 6'h02;
    localparam int          SCREENS       = 8;
    localparam logic [7:0]  ROT_MASK0     = 8'h0F;
    localparam logic [7:0]  ROT_MASK1     = 8'h33;
    localparam logic [7:0]  ROT_MASK2     = 8'hFF;
    localparam logic [2:0]  SCR_COUNT0    = 3'h3;
    localparam logic [2:0]  SCR_COUNT1    = 3'h5;
    localparam logic [2:0]  SCR_COUNT2    = 3'h7;
    localparam longint      CLK_HZ        = 200_000_000;
    localparam longint      SAVE_S        = 300;
    localparam longint      ERR_HOLD_S    = 5;
    localparam longint      IDLE_S        = 60;
    localparam longint      REFRESH_S     = 1;
    localparam longint      SAVE_CYC      = SAVE_S * CLK_HZ;
    localparam longint      ERR_HOLD_CYC  = ERR_HOLD_S * CLK_HZ;
    localparam longint      IDLE_CYC      = IDLE_S * CLK_HZ;
    localparam longint      SEC_CYC       = REFRESH_S * CLK_HZ;
    typedef enum logic [1:0] {
        MMD_T_ACC  = 2'b00,
        MMD_T_SQRT = 2'b01,
        MMD_T_DIV  = 2'b10
    } mmd_thd_t;
endpackage
`default_nettype wire

// [logic/mmd_core.sv]
/*
 * Min/max bookkeeping, mains-frequency selection, energy clear, THD and
 * measured-value screen sequencing of a power meter.
 * Assumes results, harmonic magnitudes and buttons arrive synchronous to clk
 * and that parameter writes come one word per strobe.
 */
`default_nettype none
module mmd_core #(
    parameter int     W          = 16,
    parameter int     AVG_SHIFT  = 4,
    parameter int     SPP        = 128,
    parameter longint SAVE_CYC   = mmd_pkg::SAVE_CYC,
    parameter longint HOLD_CYC   = mmd_pkg::ERR_HOLD_CYC,
    parameter longint IDLE_CYC   = mmd_pkg::IDLE_CYC,
    parameter longint SEC_CYC    = mmd_pkg::SEC_CYC,
    parameter logic [7:0] CUST_ROT   = 8'h01,
    parameter logic [2:0] CUST_COUNT = 3'h1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         param_wr,
    input  wire logic         param_rd,
    input  wire logic [9:0]   param_addr,
    input  wire logic [15:0]  param_wdata,
    output logic      [15:0]  param_rdata,
    input  wire logic         block_done,
    input  wire logic [W-1:0] meas_value,
    input  wire logic [15:0]  phase_one_voltage_input,
    input  wire logic         freq_valid,
    input  wire logic [15:0]  freq_meas,
    input  wire logic         err_ack,
    input  wire logic         harm_valid,
    input  wire logic [5:0]   harm_order,
    input  wire logic [15:0]  harm_mag,
    input  wire logic         button,
    output logic      [W-1:0] avg_value,
    output logic      [W-1:0] min_value,
    output logic      [W-1:0] max_value,
    output logic              nv_save,
    output logic              energy_clear,
    output logic      [15:0]  freq_used,
    output logic      [31:0]  sample_rate,
    output logic      [15:0]  error_code,
    output logic      [15:0]  thd_value,
    output logic              thd_done,
    output logic              refresh,
    output logic      [1:0]   screen_prof,
    output logic      [2:0]   screen_idx,
    output logic              rotating
);
    import mmd_pkg::*;

    // ------------------------------------------------------------
    // parameter words
    // ------------------------------------------------------------
    logic [15:0] freq_sel_reg;
    logic [1:0]  scr_prof_reg;
    logic [1:0]  rot_prof_reg;
    logic [5:0]  rot_time_reg;
    logic        ext_clr;
    logic        nrg_clr;
    logic        wr_freq_ok;

    assign ext_clr = param_wr && param_addr == ADDR_EXT_CLR && param_wdata == CMD_CLEAR; // [R05]
    assign nrg_clr = param_wr && param_addr == ADDR_NRG_CLR && param_wdata == CMD_CLEAR; // [R13]
    assign wr_freq_ok = param_wdata == FREQ_AUTO ||
                        (param_wdata >= FREQ_MIN && param_wdata <= FREQ_MAX);

    // out-of-range values are ignored so the previous setting stays valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_sel_reg <= FREQ_RST;
            scr_prof_reg <= 2'h0;
            rot_prof_reg <= 2'h0;
            rot_time_reg <= 6'h00;
        end else if (param_wr) begin
            if (param_addr == ADDR_FREQ && wr_freq_ok)
                freq_sel_reg <= param_wdata;                        // [R12]
            if (param_addr == ADDR_SCR_PROF && param_wdata <= PROF_MAX)
                scr_prof_reg <= param_wdata[1:0];                   // [R21]
            if (param_addr == ADDR_ROT_PROF && param_wdata <= PROF_MAX)
                rot_prof_reg <= param_wdata[1:0];                   // [R20]
            if (param_addr == ADDR_ROT_TIME && param_wdata <= ROT_TIME_MAX)
                rot_time_reg <= param_wdata[5:0];                   // [R19]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            param_rdata <= 16'h0000;
        else if (param_rd) begin
            case (param_addr)
                ADDR_FREQ:     param_rdata <= freq_sel_reg;
                ADDR_SCR_PROF: param_rdata <= {14'h0000, scr_prof_reg};
                ADDR_ROT_PROF: param_rdata <= {14'h0000, rot_prof_reg};
                ADDR_ROT_TIME: param_rdata <= {10'h000, rot_time_reg};
                default:       param_rdata <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            energy_clear <= 1'b0;
        else
            energy_clear <= nrg_clr;                                // [R13]
    end

    // ------------------------------------------------------------
    // averaging and extremes
    // ------------------------------------------------------------
    logic        ext_empty_reg;
    logic [63:0] save_cnt_reg;

    // one result per block; shift chosen so 95% is reached in the set time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            avg_value <= '0;
        else if (block_done)                                        // [R02]
            avg_value <= W'($signed({1'b0, avg_value}) +
                ($signed({1'b0, meas_value} - {1'b0, avg_value}) >>> AVG_SHIFT)); // [R01]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            min_value     <= '1;
            max_value     <= '0;
            ext_empty_reg <= 1'b1;
        end else if (ext_clr) begin
            min_value     <= '1;                                    // [R05]
            max_value     <= '0;
            ext_empty_reg <= 1'b1;
        end else if (block_done) begin
            ext_empty_reg <= 1'b0;
            if (ext_empty_reg || meas_value < min_value)
                min_value <= meas_value;                            // [R03]
            if (ext_empty_reg || meas_value > max_value)
                max_value <= meas_value;                            // [R03]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            save_cnt_reg <= 64'h0;
            nv_save      <= 1'b0;
        end else begin
            nv_save <= save_cnt_reg == 64'(SAVE_CYC - 1);           // [R04]
            if (save_cnt_reg == 64'(SAVE_CYC - 1))
                save_cnt_reg <= 64'h0;
            else
                save_cnt_reg <= save_cnt_reg + 64'h1;
        end
    end

    // ------------------------------------------------------------
    // mains frequency
    // ------------------------------------------------------------
    logic        auto_mode;
    logic        v_ok;
    logic [63:0] hold_cnt_reg;

    assign auto_mode = freq_sel_reg == FREQ_AUTO;
    assign v_ok      = phase_one_voltage_input > PH1_THRESH && freq_valid; // [R06]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            freq_used <= 16'h0032;
        else if (!auto_mode)
            freq_used <= freq_sel_reg;
        else if (v_ok)
            freq_used <= freq_meas;                                 // [R09]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            sample_rate <= 32'h0;
        else
            sample_rate <= 32'(freq_used * SPP);                    // [R07]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            error_code   <= 16'h0000;
            hold_cnt_reg <= 64'h0;
        end else begin
            if (!auto_mode) begin
                error_code   <= 16'h0000;                           // [R11]
                hold_cnt_reg <= 64'h0;
            end else if (!v_ok) begin
                error_code   <= ERR_CODE;                           // [R08]
                hold_cnt_reg <= 64'h0;
            end else if (error_code != 16'h0000) begin
                if (err_ack || hold_cnt_reg == 64'(HOLD_CYC - 1))
                    error_code <= 16'h0000;                         // [R10]
                hold_cnt_reg <= hold_cnt_reg + 64'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // total harmonic distortion
    // ------------------------------------------------------------
    mmd_thd_t    thd_st_reg;
    logic [37:0] sum_reg;
    logic [15:0] fund_reg;
    logic [31:0] rem_reg;
    logic [15:0] root_reg;
    logic [4:0]  step_reg;
    logic [31:0] trial;

    assign trial = {rem_reg[29:0], sum_reg[37:36]} - {14'h0, root_reg, 2'b01};

    // bit-serial root then 8.8 fixed-point quotient; sum keeps its low 32 bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thd_st_reg <= MMD_T_ACC;
            sum_reg    <= '0;
            fund_reg   <= '0;
            rem_reg    <= '0;
            root_reg   <= '0;
            step_reg   <= '0;
            thd_value  <= '0;
            thd_done   <= 1'b0;
        end else begin
            thd_done <= 1'b0;
            case (thd_st_reg)
                MMD_T_ACC: if (harm_valid) begin
                    if (harm_order == 6'h01) begin
                        fund_reg <= harm_mag;
                        sum_reg  <= '0;
                    end else if (harm_order >= HARM_FIRST && harm_order <= HARM_LAST) begin
                        sum_reg <= sum_reg + 38'(harm_mag * harm_mag);      // [R15]
                    end
                    if (harm_order == HARM_LAST) begin                   // [R14]
                        thd_st_reg <= MMD_T_SQRT;
                        rem_reg    <= '0;
                        root_reg   <= '0;
                        step_reg   <= 5'h0;
                        sum_reg    <= {32'(sum_reg + 38'(harm_mag * harm_mag)), 6'h00};
                    end
                end
                MMD_T_SQRT: begin
                    sum_reg <= {sum_reg[35:0], 2'b00};
                    if (!trial[31]) begin
                        rem_reg  <= trial;
                        root_reg <= {root_reg[14:0], 1'b1};
                    end else begin
                        rem_reg  <= {rem_reg[29:0], sum_reg[37:36]};
                        root_reg <= {root_reg[14:0], 1'b0};
                    end
                    step_reg <= step_reg + 5'h1;
                    if (step_reg == 5'hF) begin
                        thd_st_reg <= MMD_T_DIV;
                        step_reg   <= 5'h0;
                        rem_reg    <= '0;
                    end
                end
                MMD_T_DIV: begin
                    // restoring divide of root<<8 by the fundamental
                    if ({rem_reg[30:0], root_reg[15]} >= {16'h0, fund_reg}) begin
                        rem_reg   <= {rem_reg[30:0], root_reg[15]} - {16'h0, fund_reg};
                        thd_value <= {thd_value[14:0], 1'b1};
                    end else begin
                        rem_reg   <= {rem_reg[30:0], root_reg[15]};
                        thd_value <= {thd_value[14:0], 1'b0};
                    end
                    root_reg <= {root_reg[14:0], 1'b0};
                    step_reg <= step_reg + 5'h1;
                    if (step_reg == 5'h17) begin
                        thd_st_reg <= MMD_T_ACC;
                        thd_done   <= 1'b1;                          // [R15]
                        sum_reg    <= '0;
                    end
                end
                default: thd_st_reg <= MMD_T_ACC;
            endcase
        end
    end

    // ------------------------------------------------------------
    // display sequencing
    // ------------------------------------------------------------
    function automatic logic [2:0] next_on(input logic [7:0] m, input logic [2:0] i);
        logic [2:0] r;
        r = i;
        for (int k = SCREENS - 1; k >= 1; k--)
            if (m[3'(i + 3'(k))])
                r = 3'(i + 3'(k));
        return r;
    endfunction

    logic [7:0]  rot_mask;
    logic [2:0]  scr_last;
    logic [63:0] sec_cnt_reg;
    logic [63:0] idle_cnt_reg;
    logic [5:0]  rot_cnt_reg;
    logic        tick;

    always_comb begin
        case (rot_prof_reg)
            2'h0:    rot_mask = ROT_MASK0;
            2'h1:    rot_mask = ROT_MASK1;
            2'h2:    rot_mask = ROT_MASK2;
            default: rot_mask = CUST_ROT;
        endcase
        case (scr_prof_reg)
            2'h0:    scr_last = SCR_COUNT0;
            2'h1:    scr_last = SCR_COUNT1;
            2'h2:    scr_last = SCR_COUNT2;
            default: scr_last = CUST_COUNT;
        endcase
    end

    assign tick = sec_cnt_reg == 64'(SEC_CYC - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_reg <= 64'h0;
            refresh     <= 1'b0;
        end else begin
            refresh     <= tick;                                    // [R16]
            sec_cnt_reg <= tick ? 64'h0 : sec_cnt_reg + 64'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_reg <= 64'h0;
            rotating     <= 1'b0;
        end else if (button) begin
            idle_cnt_reg <= 64'h0;
            rotating     <= 1'b0;                                   // [R18]
        end else if (idle_cnt_reg == 64'(IDLE_CYC - 1)) begin
            rotating     <= rot_time_reg != 6'h00 && rot_mask != 8'h00; // [R17]
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 64'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            screen_prof <= 2'h0;
            screen_idx  <= 3'h0;                                    // [R22]
            rot_cnt_reg <= 6'h00;
        end else begin
            screen_prof <= scr_prof_reg;
            if (button) begin
                rot_cnt_reg <= 6'h00;
                screen_idx  <= screen_idx >= scr_last ? 3'h0 : screen_idx + 3'h1; // [R18]
            end else if (rotating && tick && rot_time_reg != 6'h00) begin
                if (rot_cnt_reg + 6'h01 >= rot_time_reg) begin
                    rot_cnt_reg <= 6'h00;
                    screen_idx  <= next_on(rot_mask, screen_idx);   // [R23]
                end else begin
                    rot_cnt_reg <= rot_cnt_reg + 6'h01;             // [R19]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ext_clear_a: assert property (ext_clr |=> min_value == '1 && max_value == '0) // [R05]
        else $error("extremes not cleared");
    min_track_a: assert property (block_done && !ext_clr && meas_value < min_value
        |=> min_value == $past(meas_value))                          // [R03]
        else $error("minimum not replaced");
    max_order_a: assert property (!ext_empty_reg |-> min_value <= max_value) // [R03]
        else $error("minimum above maximum");
    nrg_pulse_a: assert property (nrg_clr |=> energy_clear ##1 // [R13]
        (!energy_clear || $past(nrg_clr)))
        else $error("energy clear not a pulse");
    fixed_err_a: assert property (!auto_mode |=> error_code == 16'h0000) // [R11]
        else $error("error shown in fixed mode");
    miss_err_a: assert property (auto_mode && !v_ok |=> error_code == ERR_CODE) // [R08]
        else $error("missing voltage not flagged");
    hold_freq_a: assert property (auto_mode && !v_ok && $stable(freq_sel_reg)
        |=> $stable(freq_used))                                      // [R09]
        else $error("frequency changed without measurement");
    freq_range_a: assert property (freq_sel_reg == 16'h0 ||
        (freq_sel_reg >= FREQ_MIN && freq_sel_reg <= FREQ_MAX))      // [R12]
        else $error("frequency setting out of range");
    rot_stop_a: assert property (rot_time_reg == 6'h00 && !button |=> $stable(screen_idx)) // [R19]
        else $error("rotation with zero time");
    btn_stop_a: assert property (button |=> !rotating)              // [R18]
        else $error("rotation not stopped by button");

    rotate_c: cover property (rotating && tick ##1 $changed(screen_idx));
    err_gone_c: cover property (error_code == ERR_CODE ##[1:20] error_code == 16'h0000);
    thd_c: cover property (thd_done);
endmodule
`default_nettype wire

// [dv/mmd_panel_model.sv]
/* front panel model: turns a press request into one button pulse.
   assumes requests come from the bench on the rising clk edge. */
`default_nettype none
module mmd_panel_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic press_req,
    output var  logic button
);
    timeunit 1ns;
    timeprecision 1ps;
    // a press lasts as long as press_req is held, one clk later, as a debounced key would deliver
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) button <= 1'b0;
        else button <= press_req;
    end
endmodule
`default_nettype wire

// [dv/mmd_core_tb_top.sv]
/* self-checking bench for mmd_core with shortened second counts.
   assumes the assertions live in the design files. */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module mmd_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mmd_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, bd = 0, fv = 0, req = 0, button;
    logic hv = 0, ea = 0;
    logic [9:0] addr = 0;
    logic [5:0] ho = 0;
    logic [15:0] wd = 0, rdat, pv = 0, fm = 16'h0032, mv = 0, mn, mx, fu, ec;
    logic [15:0] emn, emx, thd, hm = 0, h, av;
    logic [2:0] pe;
    logic [31:0] sr;
    logic [2:0] si;
    logic [1:0] sp;
    logic nv, eclr, rot, td, rf;
    int fail_count = 0, cmp_count = 0, cyc = 0, n, s;
    int seed = 32'ha519;
    mmd_core #(.SAVE_CYC(100), .HOLD_CYC(50), .IDLE_CYC(60), .SEC_CYC(10)) dut (
        .clk(clk), .rst_n(rst_n), .param_wr(wr), .param_rd(rd), .param_addr(addr),
        .param_wdata(wd), .param_rdata(rdat), .block_done(bd), .meas_value(mv),
        .phase_one_voltage_input(pv), .freq_valid(fv), .freq_meas(fm), .err_ack(ea),
        .harm_valid(hv), .harm_order(ho), .harm_mag(hm), .button(button),
        .avg_value(av), .min_value(mn), .max_value(mx), .nv_save(nv),
        .energy_clear(eclr), .freq_used(fu), .sample_rate(sr), .error_code(ec),
        .thd_value(thd), .thd_done(td), .refresh(rf), .screen_prof(sp),
        .screen_idx(si), .rotating(rot));
    mmd_panel_model panel (.clk(clk), .rst_n(rst_n), .press_req(req), .button(button));
    // ---------------------------------------------------------------
    // bus and panel tasks
    // ---------------------------------------------------------------
    initial forever #2.5 clk = ~clk;
    task automatic wrp(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk); wr <= 1; addr <= a; wd <= d;
        @(posedge clk); wr <= 0;
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [15:0] e);
        @(posedge clk); rd <= 1; addr <= a;
        @(posedge clk); rd <= 0;
        #1;
        `CHK(rdat, e)
    endtask
    task automatic press(input logic [2:0] e);
        @(posedge clk); req <= 1;
        @(posedge clk); req <= 0;
        @(posedge clk); #1;
        `CHK(si, e)
        `CHK(rot, 1'b0)
    endtask
    // integer square root of the harmonic power sum
    function automatic int isq(input int v);
        int r;
        r = 0;
        while ((r + 1) * (r + 1) <= v) r++;
        return r;
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // timeout: the whole sequence needs well under 3000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin fail_count++; results(); end
    end
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        #1;
        `CHK(mn, 16'hFFFF)
        `CHK(fu, 16'h0032)
        `CHK(si, 3'h0)
        press(3'h1); press(3'h2); press(3'h3); press(3'h0);
        repeat (70) @(posedge clk);
        #1;
        `CHK(rot, 1'b0)
        $display("test panel done");
        wrp(ADDR_ROT_TIME, 16'h003D); rdchk(ADDR_ROT_TIME, 16'h0000);
        wrp(ADDR_ROT_TIME, 16'h0001); rdchk(ADDR_ROT_TIME, 16'h0001);
        wrp(ADDR_ROT_PROF, 16'h0004); rdchk(ADDR_ROT_PROF, 16'h0000);
        wrp(ADDR_ROT_PROF, 16'h0003); rdchk(ADDR_ROT_PROF, 16'h0003);
        wrp(ADDR_SCR_PROF, 16'h0004); rdchk(ADDR_SCR_PROF, 16'h0000);
        wrp(ADDR_SCR_PROF, 16'h0002); rdchk(ADDR_SCR_PROF, 16'h0002);
        wrp(ADDR_FREQ, 16'h002C); rdchk(ADDR_FREQ, 16'h0000);
        wrp(ADDR_FREQ, 16'h0041); rdchk(ADDR_FREQ, 16'h0041);
        rdchk(10'h3FF, 16'h0000);
        `CHK(sr, 32'd65 * 32'd128)
        `CHK(sp, 2'h2)
        repeat (80) @(posedge clk);
        #1;
        `CHK(rot, 1'b1)
        wrp(ADDR_ROT_PROF, 16'h0000); #1;
        while (!rf) begin @(posedge clk); #1; end
        for (int i = 0; i < 5; i++) begin
            pe = si;
            n = 0;
            do begin @(posedge clk); #1; n++; end while (!rf && n < 20);
            `CHK(n, 10)
            `CHK(si, (pe + 3'h1) & 3'h3)
        end
        $display("test params done");
        emn = 16'hFFFF; emx = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk); bd <= 1; mv <= 16'($random(seed));
            @(posedge clk); bd <= 0;
            if (mv < emn) emn = mv;
            if (mv > emx) emx = mv;
        end
        @(posedge clk); #1;
        `CHK(mn, emn)
        `CHK(mx, emx)
        wrp(ADDR_EXT_CLR, 16'h0002); @(posedge clk); #1;
        `CHK(mx, emx)
        wrp(ADDR_EXT_CLR, CMD_CLEAR); @(posedge clk); #1;
        `CHK({mn, mx}, 32'hFFFF0000)
        for (int i = 0; i < 60; i++) begin
            @(posedge clk); bd <= 1; mv <= 16'hFFFF;
            @(posedge clk); bd <= 0;
        end
        #1;
        `CHK(av >= 16'hF332, 1'b1)
        `CHK({mn, mx}, 32'hFFFFFFFF)
        wrp(ADDR_NRG_CLR, CMD_CLEAR); #1;
        `CHK(eclr, 1'b1)
        @(posedge clk); #1;
        `CHK(eclr, 1'b0)
        n = 0;
        while (!nv && n < 110) begin @(posedge clk); #1; n++; end
        n = 0;
        do begin @(posedge clk); #1; n++; end while (!nv && n < 110);
        `CHK(n, 100)
        $display("test extremes done");
        wrp(ADDR_FREQ, FREQ_AUTO); pv <= 0; fv <= 0;
        repeat (5) @(posedge clk); #1;
        `CHK(ec, ERR_CODE)
        `CHK(fu, 16'h0041)
        @(posedge clk); pv <= 16'h1000; fv <= 1; fm <= 16'h003C;
        repeat (20) @(posedge clk); #1;
        `CHK(ec, ERR_CODE)
        repeat (50) @(posedge clk); #1;
        `CHK(ec, 16'h0000)
        `CHK(sr, 32'd60 * 32'd128)
        @(posedge clk); pv <= PH1_THRESH;
        repeat (3) @(posedge clk); #1;
        `CHK(ec, ERR_CODE)
        @(posedge clk); pv <= 16'h1000;
        repeat (5) @(posedge clk); ea <= 1;
        @(posedge clk); ea <= 0; #1;
        `CHK(ec, 16'h0000)
        wrp(ADDR_FREQ, 16'h002D); pv <= 16'h03E8; fv <= 0;
        repeat (5) @(posedge clk); #1;
        `CHK(ec, 16'h0000)
        `CHK(fu, 16'h002D)
        $display("test frequency done");
        s = 0;
        @(posedge clk); hv <= 1; ho <= 6'h01; hm <= 16'h0040;
        for (int i = 2; i <= 40; i++) begin
            h = {8'h00, 8'($random(seed))};
            @(posedge clk); ho <= 6'(i); hm <= h;
            s += h * h;
        end
        @(posedge clk); hv <= 0;
        n = 0;
        while (!td && n < 60) begin @(posedge clk); #1; n++; end
        `CHK(thd, 16'((isq(s) * 256) / 64))
        `CHK(n, 40)
        $display("test thd done");
        results();
    end
endmodule
`default_nettype wire
